/* File: cpc_pkg.sv */
// cpc_pkg: constants shared by the cache purge controller.
// assumes one cpu clock at 20 MHz and a plain register port.
package cpc_pkg;
  // cpu variants selected by software
  typedef enum logic [1:0] {
    VAR_SINGLE,
    VAR_MP_A,
    VAR_MP_B,
    VAR_MP_C
  } cpc_var_t;

  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_CONTEXT = 4'h8;
  localparam logic [3:0] REG_COUNT = 4'hC;

  // control fields
  localparam int CTRL_VAR_LSB = 0;
  localparam int CTRL_IDTAG_BIT = 2;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status fields
  localparam int ST_CLEAR_BIT = 0;
  localparam int ST_SET_BIT = 1;
  localparam int ST_STALL_BIT = 2;
  localparam int ST_LOCK_BIT = 3;
  localparam int ST_XLSET_BIT = 4;

  // context fields
  localparam int CTX_W = 8;
  localparam int CTX_CUR_LSB = 0;
  localparam int CTX_PREV_LSB = 8;
  localparam int CTX_TID_LSB = 16;

  // sizes of the caches
  localparam int XL_OUTER_ENTRIES = 2048;
  localparam int XL_INNER_ENTRIES = 256;
  localparam int XL_IDX_W = $clog2(XL_OUTER_ENTRIES);
  localparam int IC_BYTES_B = 16384;
  localparam int IC_WORDS_C = 4096;
  localparam int DC_BYTES_A = 4096;
  localparam int DC_PAGES_LATE = 4;

  // timing: cpu clock, clearing of the spare icache validity set, translator purge gap
  localparam int CLK_MHZ = 20;
  localparam int IC_CLEAR_CYCLES = 1024;
  localparam int XL_PURGE_GAP_CYCLES = 1023;
  localparam int CLR_W = $clog2(IC_CLEAR_CYCLES + 1);
endpackage

/* File: cpc_purge_ctrl.sv */
// cpc_purge_ctrl: decides when icache, dcache and translation
// caches are purged, and gates lock read-modify-write.
// assumes all event inputs are one-cycle pulses on sys_clk.
//
// Contract
// - single cpu: traps and interrupts purge the icache.
// - single cpu: purge-all purges icache, dcache, whole translator.
// - single cpu: purge-entry purges icache, dcache, one translator entry.
// - single cpu: icache op purges icache only; dcache op dcache only.
// - single cpu: descriptor loads purge icache, dcache, whole translator.
// - mp: descriptor loads drop icache and translations of previous context.
// - mp: purge icache on thread end, icache op, idle entry.
// - mp: purge-all whole translator, purge-entry one; software purges before return.
// - mp A: translations tagged by context and thread; two validity sets.
// - mp B: translator has 2k outer and 256 inner entries.
// - mp C: entry purge hits level two only; purge-all both levels.
// - icache untagged: purge whenever context or thread number changes.
// - idle with next context always purges the icache.
// - mp A: purge swaps validity set, clears old in 1024, stalls early.
// - later mp: icache purge is fast, 16 Kbytes or 4k words.
// - mp A: remote store on any memory port invalidates the dcache.
// - lock ops wait for stores to drain, then do read-modify-write.
// - later: dcache virtually tagged, four pages; encache bit per page.
// - dcache keeps threaded and nonthreaded sets; sync clears nonthreaded.
module cpc_purge_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // traps and interrupts
  input wire logic evTraceTrap,
  input wire logic evVecTrap,
  input wire logic evArithTrap,
  input wire logic evIntr,
  // purge instructions
  input wire logic opPurgeAll,
  input wire logic opPurgeEntry,
  input wire logic [10:0] opEntryIdx,
  input wire logic opPurgeIcache,
  input wire logic opPurgeDcache,
  input wire logic opLoadDesc,
  input wire logic opMsync,
  // context events
  input wire logic ctxWrite,
  input wire logic tidWrite,
  input wire logic [7:0] ctxValue,
  input wire logic threadTerm,
  input wire logic idleNextCtx,
  // memory ports of other cpus
  input wire logic [3:0] remoteStore,
  // lock operations
  input wire logic lockReq,
  input wire logic storesPending,
  // purge commands to the caches, plus cpu stall and lock grant
  output logic icPurge,
  output logic icSetSel,
  output logic dcPurge,
  output logic dcNtPurge,
  output logic xlPurgeAll,
  output logic xlPurgeEntry,
  output logic [10:0] xlEntryIdx,
  output logic xlL1Purge,
  output logic xlSetSel,
  output logic ctxPurge,
  output logic [7:0] ctxPurgeId,
  output logic cpuStall,
  output logic lockGo
);
  typedef enum logic [1:0] {LK_IDLE, LK_DRAIN, LK_RMW} cpc_lock_t;
  localparam int CLR_W = cpc_pkg::CLR_W;

  logic [31:0] ctrl_r;
  logic [7:0] ctx_r;
  logic [7:0] prevCtx_r;
  logic [7:0] tid_r;
  logic [CLR_W-1:0] clr_r;
  logic pend_r;
  logic [15:0] purgeCnt_r;
  cpc_lock_t lock_r;
  logic [3:0] storeSeen_r;
  cpc_pkg::cpc_var_t mode;
  logic icReq;
  logic icDo;
  logic dcReq;
  logic xlAllReq;
  logic xlOneReq;
  logic ctxChg;
  logic tidChg;
  logic isMp;

  localparam logic [CLR_W-1:0] CLR_LOAD =
    CLR_W'(cpc_pkg::IC_CLEAR_CYCLES);

  function automatic logic [31:0] rdMux(input logic [3:0] a);
    case (a)
      cpc_pkg::REG_CTRL: rdMux = ctrl_r;
      cpc_pkg::REG_STATUS: rdMux = {27'h000_0000, xlSetSel,
        lock_r != LK_IDLE, cpuStall, icSetSel, clr_r != '0};
      cpc_pkg::REG_CONTEXT: rdMux = {8'h00, tid_r, prevCtx_r, ctx_r};
      cpc_pkg::REG_COUNT: rdMux = {16'h0000, purgeCnt_r};
      default: rdMux = 32'h0000_0000;
    endcase
  endfunction

  assign mode = cpc_pkg::cpc_var_t'(ctrl_r[cpc_pkg::CTRL_VAR_LSB +: 2]);
  assign isMp = mode != cpc_pkg::VAR_SINGLE;
  assign ctxChg = ctxWrite && ctxValue != ctx_r;
  assign tidChg = tidWrite && ctxValue != tid_r;

  // what each event purges, by variant
  always_comb begin
    icReq = 1'b0;
    dcReq = 1'b0;
    xlAllReq = 1'b0;
    xlOneReq = 1'b0;
    if (!isMp) begin
      icReq = evTraceTrap | evVecTrap | evArithTrap | evIntr;
      icReq = icReq | opPurgeAll | opPurgeEntry;
      icReq = icReq | opPurgeIcache | opLoadDesc;
      dcReq = opPurgeAll | opPurgeEntry;
      dcReq = dcReq | opPurgeDcache | opLoadDesc;
      xlAllReq = opPurgeAll | opLoadDesc;
      xlOneReq = opPurgeEntry;
    end else begin
      icReq = threadTerm | opPurgeIcache | opLoadDesc;
      dcReq = opPurgeDcache;
      xlAllReq = opPurgeAll;
      xlOneReq = opPurgeEntry;
    end
    // untagged icache must follow context and thread changes
    icReq = icReq | ctxChg | tidChg;
    icReq = icReq | idleNextCtx;
    if (mode == cpc_pkg::VAR_MP_A && remoteStore != 4'h0) begin
      dcReq = 1'b1;
    end
  end

  // mp A purges only once the spare set is clear
  assign icDo = mode == cpc_pkg::VAR_MP_A ?
    ((icReq | pend_r) && clr_r == '0) : icReq;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= cpc_pkg::CTRL_RESET;
    end else if (regWr && regAddr == cpc_pkg::REG_CTRL) begin
      ctrl_r <= {29'h0000_0000, regWdata[2:0]};
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 32'h0000_0000;
    end else if (regRd) begin
      regRdata <= rdMux(regAddr);
    end else begin
      regRdata <= 32'h0000_0000;
    end
  end

  // context tracking; previous context is kept for descriptor loads
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctx_r <= 8'h00;
      prevCtx_r <= 8'h00;
      tid_r <= 8'h00;
    end else begin
      if (ctxWrite) begin
        prevCtx_r <= ctx_r;
        ctx_r <= ctxValue;
      end
      if (tidWrite) begin
        tid_r <= ctxValue;
      end
    end
  end

  // icache validity set swap and background clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clr_r <= '0;
      pend_r <= 1'b0;
      icSetSel <= 1'b0;
      cpuStall <= 1'b0;
      icPurge <= 1'b0;
    end else begin
      icPurge <= icDo;
      if (mode == cpc_pkg::VAR_MP_A) begin
        if (icDo) begin
          icSetSel <= ~icSetSel;
          clr_r <= CLR_LOAD;
          pend_r <= 1'b0;
          cpuStall <= 1'b0;
        end else begin
          if (clr_r != '0) begin
            clr_r <= clr_r - CLR_W'(1);
          end
          if (icReq) begin
            pend_r <= 1'b1;
          end
          cpuStall <= icReq | pend_r;
        end
      end else begin
        clr_r <= '0;
        pend_r <= 1'b0;
        cpuStall <= 1'b0;
      end
    end
  end

  // dcache sets and translator purges
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dcPurge <= 1'b0;
      dcNtPurge <= 1'b0;
      xlPurgeAll <= 1'b0;
      xlPurgeEntry <= 1'b0;
      xlEntryIdx <= 11'h000;
      xlL1Purge <= 1'b0;
      xlSetSel <= 1'b0;
    end else begin
      // virtual tags: one purge drops every page of the dcache
      dcPurge <= dcReq;
      // sync and lock clear the nonthreaded set
      dcNtPurge <= dcReq | opMsync | (lock_r == LK_RMW);
      xlPurgeAll <= xlAllReq;
      xlPurgeEntry <= xlOneReq;
      // index spans the 2k outer level; the inner level is not ours
      xlEntryIdx <= xlOneReq ? opEntryIdx : 11'h000;
      // level one is only touched by a full purge
      xlL1Purge <= xlAllReq && mode == cpc_pkg::VAR_MP_C;
      if (xlAllReq && mode == cpc_pkg::VAR_MP_A) begin
        xlSetSel <= ~xlSetSel;
      end
    end
  end

  // descriptor load in mp drops the previous context
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctxPurge <= 1'b0;
      ctxPurgeId <= 8'h00;
    end else begin
      ctxPurge <= isMp && opLoadDesc;
      ctxPurgeId <= (isMp && opLoadDesc) ? prevCtx_r : 8'h00;
    end
  end

  // lock: drain stores, then one-cycle read-modify-write grant
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_r <= LK_IDLE;
      lockGo <= 1'b0;
    end else begin
      lockGo <= 1'b0;
      case (lock_r)
        LK_IDLE: begin
          if (lockReq) begin
            lock_r <= LK_DRAIN;
          end
        end
        LK_DRAIN: begin
          if (!storesPending) begin
            lock_r <= LK_RMW;
            lockGo <= 1'b1;
          end
        end
        LK_RMW: lock_r <= LK_IDLE;
        default: lock_r <= LK_IDLE;
      endcase
    end
  end

  // count of performed icache purges for software
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      purgeCnt_r <= 16'h0000;
    end else if (regWr && regAddr == cpc_pkg::REG_COUNT) begin
      purgeCnt_r <= 16'h0000;
    end else if (icDo) begin
      purgeCnt_r <= purgeCnt_r + 16'h0001;
    end
  end

  // remote stores seen, kept only for the check below
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      storeSeen_r <= 4'h0;
    end else begin
      storeSeen_r <= remoteStore;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_trap_icache: assert property (
    (mode == cpc_pkg::VAR_SINGLE && (evTraceTrap || evIntr))
    |=> icPurge)
    else $error("trap did not purge icache");

  a_all_purges_three: assert property (
    (mode == cpc_pkg::VAR_SINGLE && opPurgeAll)
    |=> icPurge && dcPurge && xlPurgeAll && !xlPurgeEntry)
    else $error("purge-all missed a cache");

  a_entry_single: assert property (
    (mode == cpc_pkg::VAR_SINGLE && opPurgeEntry && !opPurgeAll
     && !opLoadDesc) |=> xlPurgeEntry && !xlPurgeAll && dcPurge)
    else $error("entry purge wrong");

  a_desc_prev_ctx: assert property (
    (isMp && opLoadDesc) |=> ctxPurge && ctxPurgeId == $past(prevCtx_r))
    else $error("previous context not dropped");

  a_level_two_only: assert property (
    (mode == cpc_pkg::VAR_MP_C && opPurgeEntry && !opPurgeAll)
    |=> xlPurgeEntry && !xlL1Purge)
    else $error("entry purge touched level one");

  a_ctx_change_icache: assert property (
    (ctxChg && mode != cpc_pkg::VAR_MP_A) |=> icPurge)
    else $error("context change kept icache");

  a_clear_window: assert property (
    (mode == cpc_pkg::VAR_MP_A && icPurge) |-> clr_r == CLR_LOAD)
    else $error("clear window wrong length");

  a_early_stall: assert property (
    (mode == cpc_pkg::VAR_MP_A && icReq && clr_r > CLR_W'(1))
    |=> cpuStall && !icPurge)
    else $error("early purge did not stall");

  a_snoop_inval: assert property (
    (mode == cpc_pkg::VAR_MP_A && remoteStore != 4'h0)
    |=> dcPurge && storeSeen_r != 4'h0)
    else $error("remote store ignored");

  a_lock_drain: assert property (
    lockGo |-> $past(lock_r) == LK_DRAIN && !$past(storesPending))
    else $error("lock went before stores drained");

  a_sync_nonthread: assert property (
    opMsync |=> dcNtPurge)
    else $error("sync kept nonthreaded set");

  a_idle_icache: assert property (
    (mode != cpc_pkg::VAR_MP_A && idleNextCtx) |=> icPurge)
    else $error("idle with next context kept icache");

  a_xl_set_swap: assert property (
    (mode == cpc_pkg::VAR_MP_A && opPurgeAll)
    |=> xlSetSel != $past(xlSetSel))
    else $error("translator validity set not swapped");
endmodule

/* File: cpc_mem_model.sv */
// cpc_mem_model: memory ports on the far side of the purge controller.
// assumes the bench pulses drainReq and snoopPort after a clock edge.
module cpc_mem_model #(
  parameter int DRAIN = 6
) (
  // clock
  input wire logic sys_clk,
  // commands from the bench
  input wire logic drainReq,
  input wire logic [3:0] snoopPort,
  // memory side
  output logic storesPending,
  output logic [3:0] remoteStore
);
  int cnt = 0;
  // own stores stay in flight for DRAIN cycles before the lock may go
  always @(posedge sys_clk) begin
    if (drainReq) cnt <= DRAIN;
    else if (cnt > 0) cnt <= cnt - 1;
    storesPending <= drainReq || cnt > 1;
    remoteStore <= snoopPort;
  end
endmodule

/* File: tb.sv */
// tb: self-checking bench for the cache purge controller.
// assumes the single cpu variant after reset and registered outputs.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdata;
  logic [14:0] ev = 15'h0000;
  logic [10:0] idx = 11'h7FF;
  logic [7:0] ctxValue = 8'h05;
  logic drainReq = 1'b0;
  logic [3:0] snoopPort = 4'h0;
  logic storesPending;
  logic [3:0] remoteStore;
  logic icPurge, icSetSel, dcPurge, dcNtPurge, xlPurgeAll, xlPurgeEntry;
  logic xlL1Purge, xlSetSel, ctxPurge, cpuStall, lockGo;
  logic [10:0] xlEntryIdx, seenIdx;
  logic [7:0] ctxPurgeId, s;
  logic [7:0] seenCtx;
  logic [31:0] d;
  wire [7:0] pv = {icPurge, dcPurge, xlPurgeAll, xlPurgeEntry, xlL1Purge,
    ctxPurge, lockGo, dcNtPurge};
  int errTotal = 0;
  int testsRun = 0;
  int n;
  always #25 sys_clk = ~sys_clk;

  cpc_purge_ctrl dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .evTraceTrap(ev[0]), .evVecTrap(ev[1]),
    .evArithTrap(ev[2]), .evIntr(ev[3]), .opPurgeAll(ev[4]),
    .opPurgeEntry(ev[5]), .opEntryIdx(idx), .opPurgeIcache(ev[6]),
    .opPurgeDcache(ev[7]), .opLoadDesc(ev[8]), .opMsync(ev[9]),
    .ctxWrite(ev[10]), .tidWrite(ev[11]), .ctxValue(ctxValue),
    .threadTerm(ev[12]), .idleNextCtx(ev[13]), .remoteStore(remoteStore),
    .lockReq(ev[14]), .storesPending(storesPending), .icPurge(icPurge),
    .icSetSel(icSetSel), .dcPurge(dcPurge), .dcNtPurge(dcNtPurge),
    .xlPurgeAll(xlPurgeAll), .xlPurgeEntry(xlPurgeEntry),
    .xlEntryIdx(xlEntryIdx), .xlL1Purge(xlL1Purge), .xlSetSel(xlSetSel),
    .ctxPurge(ctxPurge), .ctxPurgeId(ctxPurgeId), .cpuStall(cpuStall),
    .lockGo(lockGo));

  cpc_mem_model mem (.sys_clk(sys_clk), .drainReq(drainReq),
    .snoopPort(snoopPort), .storesPending(storesPending),
    .remoteStore(remoteStore));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (errTotal == 0 && testsRun > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  // or of all purge pulses over k cycles, so one-cycle pulses are not lost
  task automatic obs(input int k);
    s = 8'h00;
    repeat (k) begin
      #1 s |= pv;
      if (xlPurgeEntry) seenIdx = xlEntryIdx;
      if (ctxPurge) seenCtx = ctxPurgeId;
      @(posedge sys_clk);
    end
  endtask

  task automatic fire(input int b, input logic [7:0] m);
    @(posedge sys_clk);
    ev <= 15'h0001 << b;
    @(posedge sys_clk);
    ev <= 15'h0000;
    obs(3);
    s &= m;
    // leave the edge so later level checks see settled outputs
    #1;
  endtask

  initial begin
    #250000;
    errTotal++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(cpc_pkg::REG_CTRL);
    chk(d, cpc_pkg::CTRL_RESET);
    rd(4'h2);
    chk(d, 32'h0000_0000);
    // every trap kind purges the icache alone
    for (int b = 0; b < 4; b++) begin
      fire(b, 8'hFF);
      chk(s, 8'h80);
    end
    fire(4, 8'hFF);
    chk(s, 8'hE1);
    fire(5, 8'hFF);
    chk(s, 8'hD1);
    chk(seenIdx, idx);
    fire(6, 8'hFF);
    chk(s, 8'h80);
    fire(7, 8'hFF);
    chk(s, 8'h41);
    fire(8, 8'hFF);
    chk(s, 8'hE1);
    fire(13, 8'h80);
    chk(s, 8'h80);
    fire(10, 8'h80);
    chk(s, 8'h80);
    rd(cpc_pkg::REG_CONTEXT);
    chk(d[7:0], ctxValue);
    fire(11, 8'h80);
    chk(s, 8'h80);
    // lock must wait until the model's stores have drained
    @(posedge sys_clk);
    drainReq <= 1'b1;
    @(posedge sys_clk);
    drainReq <= 1'b0;
    fire(14, 8'h03);
    chk(s, 8'h00);
    obs(8);
    chk(s & 8'h03, 8'h03);
    wr(cpc_pkg::REG_CTRL, 32'(cpc_pkg::VAR_MP_C));
    fire(5, 8'h38);
    chk(s, 8'h10);
    fire(4, 8'h38);
    chk(s, 8'h28);
    // second context switch, so the previous context is not zero
    ctxValue <= 8'h0A;
    fire(10, 8'h80);
    chk(s, 8'h80);
    fire(8, 8'hFF);
    chk(s, 8'h84);
    chk(seenCtx, 8'h05);
    wr(cpc_pkg::REG_CTRL, 32'(cpc_pkg::VAR_MP_A));
    @(posedge sys_clk);
    snoopPort <= 4'h8;
    @(posedge sys_clk);
    snoopPort <= 4'h0;
    obs(4);
    chk(s & 8'h40, 8'h40);
    fire(12, 8'h80);
    chk(s, 8'h80);
    chk(icSetSel, 1'b1);
    // second purge inside the clearing span must stall, then fire
    fire(6, 8'h80);
    chk(s, 8'h00);
    chk(cpuStall, 1'b1);
    n = 0;
    while (cpuStall !== 1'b0 && n < 1100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(n > 990 && n < 1030, 1'b1);
    obs(3);
    chk(s & 8'h80, 8'h80);
    chk(icSetSel, 1'b0);
    fire(4, 8'h38);
    chk(s, 8'h20);
    chk(xlSetSel, 1'b1);
    conclude();
  end
endmodule
